// *** include/exc_seq_pkg.sv ***
// Constants, codes and carrier types for the reset and exception sequencer
package exc_seq_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] off_event_code = 8'h00;
  localparam logic [7:0] off_return_addr = 8'h04;
  localparam logic [7:0] off_vector_base = 8'h08;
  localparam logic [7:0] off_state_word = 8'h0c;
  localparam logic [7:0] off_trap_code = 8'h10;
  localparam logic [7:0] off_saved_state = 8'h14;
  // Exception event codes
  localparam logic [11:0] code_power_on = 12'h000;
  localparam logic [11:0] code_manual = 12'h020;
  localparam logic [11:0] code_debug = 12'h000;
  localparam logic [11:0] code_addr_read = 12'h0e0;
  localparam logic [11:0] code_addr_write = 12'h1e0;
  localparam logic [11:0] code_illegal = 12'h180;
  localparam logic [11:0] code_slot = 12'h1a0;
  localparam logic [11:0] code_trap = 12'h160;
  localparam logic [11:0] code_break = 12'h1e0;
  localparam logic [11:0] code_dma = 12'h5c0;
  // Addresses
  localparam logic [31:0] reset_vector = 32'ha0000000;
  localparam logic [31:0] vector_base_reset = 32'h00000000;
  localparam logic [31:0] general_offset = 32'h00000100;
  // State word field positions
  localparam int psw_md = 30;
  localparam int psw_bnk = 29;
  localparam int psw_blk = 28;
  localparam int psw_dsp = 12;
  localparam int psw_imask_lo = 4;
  localparam logic [3:0] imask_reset = 4'hf;
  // State word value after any reset: privileged, bank 1, blocked, mask 1111
  localparam logic [31:0] psw_reset = 32'h700000f0;
  // Access sizes of a data access
  localparam logic [1:0] size_byte = 2'h0;
  localparam logic [1:0] size_word = 2'h1;
  localparam logic [1:0] size_long = 2'h2;

  // Instruction at the point of acceptance, from the pipeline
  typedef struct packed {
    logic valid;         // An instruction sits at the boundary this cycle
    logic [31:0] pc;     // Its own address
    logic [31:0] next_pc; // Address of the following instruction
    logic in_slot;       // It sits in a delay slot
    logic [31:0] branch_pc; // Address of the delayed branch before it
    logic [31:0] branch_target; // Destination of that delayed branch
    logic undefined;     // Decoded as undefined code
    logic pc_changing;   // Decoded as an instruction that rewrites pc
    logic dsp_op;        // Decoded as a DSP extension instruction
    logic trap;          // Software trap instruction
    logic [7:0] trap_imm; // Its 8-bit immediate
  } instr_s;

  // Fetch and data access of that instruction
  typedef struct packed {
    logic fetch_valid;
    logic [31:0] fetch_addr;
    logic data_valid;
    logic data_write;
    logic [1:0] data_size;
    logic [31:0] data_addr;
  } access_s;

  // Break match unit requests
  typedef struct packed {
    logic pre_exec;      // Before execution, re-execution type
    logic operand;       // Operand break, completion type
    logic async_break;   // Data or bus break, asynchronous
  } break_s;
endpackage

// *** test/exc_sequencer_bench.sv ***
// Self-checking bench for the reset and exception sequencer
`timescale 1ns/10ps
`default_nettype none
module exc_sequencer_bench;
  // Clock, reset and reset sources
  logic clk, rstn, por_n, man_n, dbg;
  // Pipeline side, driven by the partner
  exc_seq_pkg::instr_s instr, ib;
  exc_seq_pkg::access_s access, an;
  exc_seq_pkg::break_s brk;
  logic dma;
  // Sequencer outputs
  logic core_reset, rv, ab;
  logic [31:0] rpc, psw_out;
  // APB wires and last answer
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd, psw;
  int n_errors, checked;
  // Handler base for the exception cases
  localparam logic [31:0] base = 32'h00004000;
  exc_sequencer dut_u (.clk, .rstn, .power_on_reset_pin_n(por_n),
    .manual_reset_pin_n(man_n), .debug_reset_cmd(dbg), .instr, .access,
    .brk, .dma_addr_err(dma), .core_reset, .redirect_valid(rv),
    .redirect_pc(rpc), .abort_current(ab), .state_word_out(psw_out), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  pipe_partner pipe_u (.clk, .instr, .access, .brk, .dma_addr_err(dma));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // APB transfer; waits on pready, the watchdog ends a hang
  task automatic apb(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for the reset redirect, then judge its record
  task automatic wait_reset(input logic [11:0] code);
    for (int k = 0; k < 40 && rv !== 1'b1; k++) @(posedge clk);
    check("reset pc", rpc, exc_seq_pkg::reset_vector);
    check("reset abort", {31'h0, ab}, 32'h1);
    apb(1'b0, exc_seq_pkg::off_event_code, 32'h0);
    check("reset code", rd, {20'h0, code});
    apb(1'b0, exc_seq_pkg::off_state_word, 32'h0);
    check("reset state", rd, exc_seq_pkg::psw_reset);
  endtask
  // Unblock, present one boundary, judge redirect and record
  task automatic take(input exc_seq_pkg::instr_s i,
    input exc_seq_pkg::access_s a, input exc_seq_pkg::break_s b,
    input logic d, input logic [11:0] code, input logic [31:0] ret,
    input logic abt);
    apb(1'b1, exc_seq_pkg::off_state_word, psw);
    // A dma fault is latched first, then waits for a boundary
    if (d) pipe_u.issue('0, an, '0, 1'b1);
    pipe_u.issue(i, a, b, 1'b0);
    @(posedge clk);
    check("redirect", {31'h0, rv}, 32'h1);
    check("handler", rpc, base + exc_seq_pkg::general_offset);
    check("abort", {31'h0, ab}, {31'h0, abt});
    apb(1'b0, exc_seq_pkg::off_event_code, 32'h0);
    check("code", rd, {20'h0, code});
    apb(1'b0, exc_seq_pkg::off_return_addr, 32'h0);
    check("return addr", rd, ret);
  endtask
  // Reset values, read-only write, unmapped place
  task automatic t_apb();
    apb(1'b0, exc_seq_pkg::off_vector_base, 32'h0);
    check("base reset", rd, 32'h0);
    apb(1'b1, exc_seq_pkg::off_event_code, 32'hffffffff);
    apb(1'b0, exc_seq_pkg::off_event_code, 32'h0);
    check("event ro", rd, 32'h0);
    apb(1'b0, 32'h00000040, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
  endtask
  // Debug reset clears the vector base
  task automatic t_debug();
    apb(1'b1, exc_seq_pkg::off_vector_base, 32'h00007700);
    @(posedge clk);
    dbg <= 1'b1;
    @(posedge clk);
    dbg <= 1'b0;
    wait_reset(12'h000);
    apb(1'b0, exc_seq_pkg::off_vector_base, 32'h0);
    check("base cleared", rd, 32'h0);
  endtask
  // Reset pin held low mid-run
  task automatic t_pin(input logic man, input logic [11:0] code);
    @(posedge clk);
    man_n <= !man;
    por_n <= man;
    repeat (6) @(posedge clk);
    check("pin reset", {31'h0, core_reset}, 32'h1);
    man_n <= 1'b1;
    por_n <= 1'b1;
    wait_reset(code);
  endtask
  // Fetch, alignment and user-space address errors
  task automatic t_addr_err();
    exc_seq_pkg::access_s a;
    exc_seq_pkg::instr_s i;
    i = ib;
    a = an;
    a.fetch_valid = 1'b1;
    a.fetch_addr = 32'h00001003;
    a.data_valid = 1'b1;
    a.data_size = exc_seq_pkg::size_word;
    a.data_addr = 32'h00000001;
    take(i, a, '0, 1'b0, 12'h0e0, 32'h00001003, 1'b1);
    a.fetch_valid = 1'b0;
    a.data_write = 1'b1;
    take(i, a, '0, 1'b0, 12'h1e0, ib.pc, 1'b1);
    a.data_write = 1'b0;
    a.data_size = exc_seq_pkg::size_long;
    a.data_addr = 32'h00000102;
    i.in_slot = 1'b1;
    take(i, a, '0, 1'b0, 12'h0e0, ib.branch_pc, 1'b1);
    a.data_size = exc_seq_pkg::size_byte;
    a.data_addr = 32'h80000000;
    psw = 32'h0;
    take(ib, a, '0, 1'b0, 12'h0e0, ib.pc, 1'b1);
    psw = 32'h40000000;
  endtask
  // Undefined, slot and DSP decode faults
  task automatic t_illegal();
    exc_seq_pkg::instr_s i;
    i = ib;
    i.undefined = 1'b1;
    i.trap = 1'b1;
    take(i, an, '0, 1'b0, 12'h180, ib.pc, 1'b1);
    i.trap = 1'b0;
    i.in_slot = 1'b1;
    take(i, an, '0, 1'b0, 12'h1a0, ib.branch_pc, 1'b1);
    i.undefined = 1'b0;
    i.pc_changing = 1'b1;
    take(i, an, '0, 1'b0, 12'h1a0, ib.branch_pc, 1'b1);
    i = ib;
    i.dsp_op = 1'b1;
    take(i, an, '0, 1'b0, 12'h180, ib.pc, 1'b1);
    apb(1'b1, exc_seq_pkg::off_state_word, 32'h40001000);
    pipe_u.issue(i, an, '0, 1'b0);
    @(posedge clk);
    check("dsp runs", {31'h0, rv}, 32'h0);
  endtask
  // Trap outranks an operand break; immediate scaled by four
  task automatic t_trap();
    exc_seq_pkg::instr_s i;
    exc_seq_pkg::break_s b;
    i = ib;
    i.trap = 1'b1;
    i.trap_imm = 8'hff;
    b = '0;
    b.operand = 1'b1;
    take(i, an, b, 1'b0, 12'h160, ib.next_pc, 1'b0);
    apb(1'b0, exc_seq_pkg::off_trap_code, 32'h0);
    check("trap code", rd, 32'h000003fc);
  endtask
  // Break kinds, blocked break and dma fault
  task automatic t_break();
    exc_seq_pkg::instr_s i;
    exc_seq_pkg::break_s b;
    i = ib;
    b = '0;
    b.pre_exec = 1'b1;
    b.operand = 1'b1;
    take(i, an, b, 1'b0, 12'h1e0, ib.pc, 1'b1);
    b.pre_exec = 1'b0;
    i.in_slot = 1'b1;
    take(i, an, b, 1'b0, 12'h1e0, ib.branch_target, 1'b0);
    b.operand = 1'b0;
    b.async_break = 1'b1;
    take(ib, an, b, 1'b0, 12'h1e0, ib.next_pc, 1'b0);
    take(ib, an, '0, 1'b1, 12'h5c0, ib.next_pc, 1'b0);
    apb(1'b1, exc_seq_pkg::off_state_word, 32'h50000000);
    pipe_u.issue(ib, an, b, 1'b0);
    @(posedge clk);
    check("blocked break", {31'h0, rv}, 32'h0);
    i = ib;
    i.trap = 1'b1;
    pipe_u.issue(i, an, '0, 1'b0);
    wait_reset(12'h020);
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    n_errors = 0;
    checked = 0;
    {rstn, dbg, psel, penable, pwrite} = 5'h00;
    {por_n, man_n} = 2'h3;
    paddr = 32'h0;
    pwdata = 32'h0;
    psw = 32'h40000000;
    an = '0;
    ib = '0;
    ib.valid = 1'b1;
    ib.pc = 32'h00001000;
    ib.next_pc = 32'h00001002;
    ib.branch_pc = 32'h00000ffe;
    ib.branch_target = 32'h00003000;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    wait_reset(12'h000);
    t_apb();
    t_debug();
    t_pin(1'b1, 12'h020);
    t_pin(1'b0, 12'h000);
    apb(1'b1, exc_seq_pkg::off_vector_base, base);
    t_addr_err();
    t_illegal();
    t_trap();
    t_break();
    summarize();
  end
endmodule
`default_nettype wire

// *** test/exc_sequencer_monitor.sv ***
// Port checker for the reset and exception sequencer
`timescale 1ns/10ps
`default_nettype none
module exc_sequencer_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Reset sources
  input wire logic power_on_reset_pin_n,
  input wire logic manual_reset_pin_n,
  input wire logic debug_reset_cmd,
  // Pipeline side
  input wire exc_seq_pkg::instr_s instr,
  input wire exc_seq_pkg::access_s access,
  input wire exc_seq_pkg::break_s brk,
  // Redirect side
  input wire logic core_reset,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire logic abort_current,
  input wire logic [31:0] state_word_out
);
  // Blocked flag as seen outside; lags the register by one cycle
  wire blk = state_word_out[exc_seq_pkg::psw_blk];
  // Boundary where an exception may be taken
  wire run = instr.valid && !blk && !core_reset && !debug_reset_cmd;
  // No higher ranked fault
  wire clean = run && !brk.pre_exec && !access.fetch_valid;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_debug_reset_jump: assert property (
    debug_reset_cmd && !core_reset |=> core_reset && redirect_valid &&
    redirect_pc == exc_seq_pkg::reset_vector)
    else $error("debug reset jump");
  chk_reset_target: assert property (
    redirect_valid && (core_reset || $past(core_reset)) |->
    redirect_pc == exc_seq_pkg::reset_vector && abort_current)
    else $error("reset redirect wrong");
  chk_reset_state: assert property (
    core_reset [*3] |=> state_word_out == exc_seq_pkg::psw_reset)
    else $error("reset state wrong");
  chk_power_pin_held: assert property (
    !power_on_reset_pin_n [*5] |-> core_reset)
    else $error("power-on pin ignored");
  chk_manual_pin_held: assert property (
    !manual_reset_pin_n [*5] |-> core_reset)
    else $error("manual pin ignored");
  chk_completion_type: assert property (
    redirect_valid && !abort_current |-> !core_reset && !$past(core_reset))
    else $error("completion in reset");
  chk_pre_break_abort: assert property (
    run && brk.pre_exec |=> redirect_valid && abort_current && !core_reset)
    else $error("pre-break not aborted");
  chk_trap_complete: assert property (
    clean && instr.trap && !instr.undefined && !instr.in_slot &&
    !instr.dsp_op && !access.data_valid |=> redirect_valid && !abort_current)
    else $error("trap not completed");
  chk_illegal_abort: assert property (
    clean && instr.undefined |=> redirect_valid && abort_current && !core_reset)
    else $error("undefined not aborted");
endmodule
bind exc_sequencer exc_sequencer_monitor mon_u (.clk, .rstn,
  .power_on_reset_pin_n, .manual_reset_pin_n, .debug_reset_cmd, .instr,
  .access, .brk, .core_reset, .redirect_valid, .redirect_pc, .abort_current,
  .state_word_out);
`default_nettype wire

// *** test/pipe_partner.sv ***
// Behavioural pipeline, break and dma side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module pipe_partner (
  // Clock
  input wire logic clk,
  // Boundary requests
  output var exc_seq_pkg::instr_s instr,
  output var exc_seq_pkg::access_s access,
  output var exc_seq_pkg::break_s brk,
  output var logic dma_addr_err
);
  // Idle at time zero
  initial begin
    instr = '0;
    access = '0;
    brk = '0;
    dma_addr_err = 1'b0;
  end
  // One boundary cycle; afterwards fields turn to garbage, not stale values
  task automatic issue(input exc_seq_pkg::instr_s i,
    input exc_seq_pkg::access_s a, input exc_seq_pkg::break_s b,
    input logic d);
    exc_seq_pkg::instr_s g;
    exc_seq_pkg::access_s h;
    g = ~i;
    g.valid = 1'b0;
    h = ~a;
    h.fetch_valid = 1'b0;
    h.data_valid = 1'b0;
    @(posedge clk);
    instr <= i;
    access <= a;
    brk <= b;
    dma_addr_err <= d;
    @(posedge clk);
    instr <= g;
    access <= h;
    brk <= '0;
    dma_addr_err <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verilog/exc_sequencer.sv ***
// Reset and general exception sequencer with APB register access
// Behaviour
// - power-on reset: code 000, jump A0000000
// - manual reset: code 020, same vector
// - power-on taken while its pin low
// - manual reset taken while its pin low
// - debug reset: code 000, vector base cleared
// - any reset sets block, bank, mask 1111
// - fetch from odd address is address error
// - misaligned word or longword data access errors
// - user access at or above 80000000 errors
// - address error re-executes; return address by kind
// - address error code 0E0 read, 1E0 write
// - undefined code outside slot: code 180
// - bad slot instruction: code 1A0, branch address
// - software trap completes, code 160, next address
// - trap immediate times four to trap code
// - break gives code 1E0, type by kind
// - operand break returns next or branch target
// - misaligned DMA address: code 5C0, asynchronous
// - DSP instruction with DSP bit clear illegal
// - resets first, then general exceptions
// - completion saves next, re-execution saves own
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module exc_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Reset sources
  input wire logic power_on_reset_pin_n,
  input wire logic manual_reset_pin_n,
  input wire logic debug_reset_cmd,
  // Pipeline, break match unit and dma unit
  input wire exc_seq_pkg::instr_s instr,
  input wire exc_seq_pkg::access_s access,
  input wire exc_seq_pkg::break_s brk,
  input wire logic dma_addr_err,
  // Redirect to the pipeline
  output logic core_reset,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic abort_current,
  output logic [31:0] state_word_out,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Sequencer states
  typedef enum logic [1:0] {
    st_reset = 2'b01,
    st_run = 2'b10
  } seq_e;

  seq_e state;                 // Current state
  seq_e next_state;            // Next state
  logic por_meta, por_sync;    // Power-on pin synchroniser
  logic man_meta, man_sync;    // Manual pin synchroniser
  logic man_seen;              // Manual reset caused the current hold
  logic [31:0] exception_event_code_reg; // Last event code
  logic [31:0] saved_return_address;     // Return address
  logic [31:0] vector_base_reg;          // Handler base
  logic [31:0] processor_state_word;     // Mode, bank, block, mask
  logic [31:0] saved_state_word;         // State word before exception
  logic [31:0] trap_code_reg;            // Trap immediate times four
  logic dma_pending;           // Held dma address error request
  logic brk_pending;           // Held asynchronous break request

  // Misalignment check for cpu data accesses
  function automatic logic misaligned(input logic [1:0] size,
                                      input logic [1:0] low);
    misaligned = (size == exc_seq_pkg::size_word && low[0]) ||
                 (size == exc_seq_pkg::size_long && low != 2'h0);
  endfunction

  // Field views of the state word
  wire user_mode = ~processor_state_word[exc_seq_pkg::psw_md];
  wire blocked = processor_state_word[exc_seq_pkg::psw_blk];
  wire dsp_on = processor_state_word[exc_seq_pkg::psw_dsp];

  // Reset requests; pins are low-active levels
  wire por_req = ~por_sync;
  wire man_req = ~man_sync;
  wire any_pin_reset = por_req | man_req;

  // Fetch fault: odd address or user access to upper space
  wire fetch_err = access.fetch_valid &
                   (access.fetch_addr[0] |
                    (user_mode & access.fetch_addr[31]));
  // Data fault: misaligned or user access to upper space
  wire data_err = instr.valid & access.data_valid &
                  (misaligned(access.data_size, access.data_addr[1:0]) |
                   (user_mode & access.data_addr[31]));
  // DSP op with DSP disabled counts as undefined code
  wire bad_code = instr.undefined | (instr.dsp_op & ~dsp_on);
  wire illegal_gen = instr.valid & ~instr.in_slot & bad_code;
  wire illegal_slot = instr.valid & instr.in_slot &
                      (bad_code | instr.pc_changing);
  wire trap_hit = instr.valid & instr.trap & ~instr.in_slot;
  wire pre_break = instr.valid & brk.pre_exec & ~blocked;
  wire op_break = instr.valid & brk.operand & ~blocked;
  // Asynchronous requests wait for a boundary; dma held while blocked, breaks dropped
  wire async_brk = instr.valid & (brk_pending | brk.async_break) &
                   ~blocked;
  wire dma_take = instr.valid & (dma_pending | dma_addr_err) & ~blocked;
  // Address of the instruction that re-executes after the handler
  wire [31:0] own_addr = instr.in_slot ? instr.branch_pc : instr.pc;
  // Completion type: next, or branch target when in a slot
  wire [31:0] next_addr = instr.in_slot ? instr.branch_target
                                        : instr.next_pc;

  // Priority selection among general exceptions
  logic gen_take;              // A general exception is taken now
  logic gen_abort;             // It is of re-execution type
  logic [11:0] gen_code;       // Its event code
  logic [31:0] gen_ret;        // Its return address
  logic synchronous_fault;     // Fault that forces reset under block
  always_comb begin
    gen_take = 1'b1;
    gen_abort = 1'b1;
    gen_code = exc_seq_pkg::code_break;
    gen_ret = own_addr;
    synchronous_fault = 1'b0;
    // Highest first; only one is taken per cycle
    if (pre_break) begin
      gen_code = exc_seq_pkg::code_break;
      gen_ret = own_addr;
    end else if (fetch_err) begin
      gen_code = exc_seq_pkg::code_addr_read;
      gen_ret = access.fetch_addr;
      synchronous_fault = 1'b1;
    end else if (illegal_gen) begin
      gen_code = exc_seq_pkg::code_illegal;
      gen_ret = instr.pc;
      synchronous_fault = 1'b1;
    end else if (illegal_slot) begin
      gen_code = exc_seq_pkg::code_slot;
      gen_ret = instr.branch_pc;
      synchronous_fault = 1'b1;
    end else if (data_err) begin
      // Fault in a slot returns to the delayed branch
      gen_code = access.data_write ? exc_seq_pkg::code_addr_write
                                   : exc_seq_pkg::code_addr_read;
      gen_ret = own_addr;
      synchronous_fault = 1'b1;
    end else if (trap_hit) begin
      gen_abort = 1'b0;
      gen_code = exc_seq_pkg::code_trap;
      gen_ret = instr.next_pc;
      synchronous_fault = 1'b1;
    end else if (op_break) begin
      gen_abort = 1'b0;
      gen_code = exc_seq_pkg::code_break;
      gen_ret = next_addr;
    end else if (async_brk) begin
      gen_abort = 1'b0;
      gen_code = exc_seq_pkg::code_break;
      gen_ret = next_addr;
    end else if (dma_take) begin
      gen_abort = 1'b0;
      gen_code = exc_seq_pkg::code_dma;
      gen_ret = next_addr;
    end else begin
      gen_take = 1'b0;
    end
  end

  // A synchronous fault with block set cannot be nested: it resets
  wire block_reset = gen_take & synchronous_fault & blocked;
  wire gen_accept = gen_take & ~block_reset;
  // Resets outrank every general exception
  wire run_state = (state == st_run);
  wire debug_reset = run_state & debug_reset_cmd & ~any_pin_reset;
  wire soft_reset = debug_reset | (run_state & block_reset);
  wire exc_commit = run_state & gen_accept & ~debug_reset &
                    ~any_pin_reset;

  // State transitions
  always_comb begin
    case (state)
      st_reset: next_state = any_pin_reset ? st_reset : st_run;
      st_run: next_state = any_pin_reset ? st_reset : st_run;
      default: next_state = st_reset;
    endcase
  end

  // APB decode
  wire apb_setup = psel & ~penable & ~pready;
  wire apb_write = psel & penable & pready & pwrite;
  wire [7:0] reg_off = paddr[7:0];
  wire mapped = (paddr[31:8] == 24'h000000) && (reg_off[1:0] == 2'h0) &&
                (reg_off <= exc_seq_pkg::off_saved_state);
  wire wr_base = apb_write & ~pslverr &
                (reg_off == exc_seq_pkg::off_vector_base);
  wire wr_psw = apb_write & ~pslverr &
                (reg_off == exc_seq_pkg::off_state_word);
  logic [31:0] read_mux;       // Read data for the addressed register
  always_comb begin
    case (reg_off)
      exc_seq_pkg::off_event_code: read_mux = exception_event_code_reg;
      exc_seq_pkg::off_return_addr: read_mux = saved_return_address;
      exc_seq_pkg::off_vector_base: read_mux = vector_base_reg;
      exc_seq_pkg::off_state_word: read_mux = processor_state_word;
      exc_seq_pkg::off_trap_code: read_mux = trap_code_reg;
      exc_seq_pkg::off_saved_state: read_mux = saved_state_word;
      default: read_mux = 32'h00000000;
    endcase
  end

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_meta <= 1'b0;
      por_sync <= 1'b0;
      man_meta <= 1'b1;
      man_sync <= 1'b1;
    end else begin
      por_meta <= power_on_reset_pin_n;
      por_sync <= por_meta;
      man_meta <= manual_reset_pin_n;
      man_sync <= man_meta;
    end
  end

  // Sequencer state and reset cause
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= st_reset;
      man_seen <= 1'b0;
    end else begin
      state <= next_state;
      // Power-on wins when both pins are low
      if (por_req) begin
        man_seen <= 1'b0;
      end else if (man_req) begin
        man_seen <= 1'b1;
      end
    end
  end

  // Held asynchronous requests; a new request beats the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dma_pending <= 1'b0;
      brk_pending <= 1'b0;
    end else if (any_pin_reset || soft_reset) begin
      dma_pending <= 1'b0;
      brk_pending <= 1'b0;
    end else begin
      // Cleared only when accepted and no fresh request arrives
      dma_pending <= dma_addr_err |
                     (dma_pending & ~(exc_commit & gen_code ==
                      exc_seq_pkg::code_dma & ~async_brk & ~op_break));
      // Breaks under block are ignored, not held
      brk_pending <= brk.async_break & ~blocked |
                     (brk_pending & ~blocked & ~(exc_commit & async_brk));
    end
  end

  // Event code, return address and trap code
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exception_event_code_reg <= {20'h00000, exc_seq_pkg::code_power_on};
      saved_return_address <= 32'h00000000;
      trap_code_reg <= 32'h00000000;
      saved_state_word <= 32'h00000000;
    end else if (any_pin_reset) begin
      exception_event_code_reg <= {20'h00000, por_req ?
        exc_seq_pkg::code_power_on : exc_seq_pkg::code_manual};
    end else if (debug_reset) begin
      exception_event_code_reg <= {20'h00000, exc_seq_pkg::code_debug};
    end else if (run_state && block_reset) begin
      exception_event_code_reg <= {20'h00000, exc_seq_pkg::code_manual};
    end else if (exc_commit) begin
      exception_event_code_reg <= {20'h00000, gen_code};
      saved_return_address <= gen_ret;
      saved_state_word <= processor_state_word;
      if (gen_code == exc_seq_pkg::code_trap && trap_hit) begin
        trap_code_reg <= {22'h000000, instr.trap_imm, 2'h0};
      end
    end
  end

  // Vector base and state word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vector_base_reg <= exc_seq_pkg::vector_base_reset;
      processor_state_word <= exc_seq_pkg::psw_reset;
    end else if (any_pin_reset || soft_reset) begin
      vector_base_reg <= exc_seq_pkg::vector_base_reset;
      processor_state_word <= exc_seq_pkg::psw_reset;
    end else if (exc_commit) begin
      // Handler runs privileged, in bank 1, with block set
      processor_state_word[exc_seq_pkg::psw_md] <= 1'b1;
      processor_state_word[exc_seq_pkg::psw_bnk] <= 1'b1;
      processor_state_word[exc_seq_pkg::psw_blk] <= 1'b1;
    end else begin
      if (wr_base) begin
        vector_base_reg <= pwdata;
      end
      if (wr_psw) begin
        processor_state_word <= pwdata;
      end
    end
  end

  // Redirect outputs to the pipeline
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_reset <= 1'b1;
      redirect_valid <= 1'b0;
      redirect_pc <= exc_seq_pkg::reset_vector;
      abort_current <= 1'b0;
    end else begin
      core_reset <= any_pin_reset | soft_reset;
      // Leaving reset, or a debug or block reset: start at the reset vector
      if ((state == st_reset && !any_pin_reset) || soft_reset) begin
        redirect_valid <= 1'b1;
        redirect_pc <= exc_seq_pkg::reset_vector;
        abort_current <= 1'b1;
      end else if (exc_commit) begin
        redirect_valid <= 1'b1;
        redirect_pc <= vector_base_reg + exc_seq_pkg::general_offset;
        abort_current <= gen_abort;
      end else begin
        redirect_valid <= 1'b0;
        abort_current <= 1'b0;
      end
    end
  end

  // State word copy for the core
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_word_out <= exc_seq_pkg::psw_reset;
    end else begin
      state_word_out <= processor_state_word;
    end
  end

  // APB answer: no wait state, data and error registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= (mapped && !pwrite) ? read_mux : 32'h00000000;
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire
